// *** acc_top.sv ***
// Purpose: ASCII interpreter for status read and channel calibration
// Assumes: Receive characters come from a line receiver on clk
// Notes:   Frames that close while a reply is still going out are dropped
`timescale 1ns/10ps
`default_nettype none
`include "acc_params.svh"
module acc_top #(
  parameter int AW    = 8,
  parameter int LVL_W = 16
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // Received characters
  input  wire logic [7:0]            rx_data,
  input  wire logic                  rx_valid,
  input  wire logic                  rx_err,
  // Reply characters
  output var  logic [7:0]            tx_data,
  output var  logic                  tx_valid,
  input  wire logic                  tx_ready,
  // Present output level per channel
  input  wire logic [1:0][LVL_W-1:0] out_level,
  // Calibration store
  output var  logic                  nv_wr_valid,
  output var  logic [1:0]            nv_wr_index,
  output var  logic [LVL_W-1:0]      nv_wr_data,
  // AXI4-Lite write
  input  wire logic [AW-1:0]         awaddr,
  input  wire logic                  awvalid,
  output var  logic                  awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output var  logic                  wready,
  output var  logic [1:0]            bresp,
  output var  logic                  bvalid,
  input  wire logic                  bready,
  // AXI4-Lite read
  input  wire logic [AW-1:0]         araddr,
  input  wire logic                  arvalid,
  output var  logic                  arready,
  output var  logic [31:0]           rdata,
  output var  logic [1:0]            rresp,
  output var  logic                  rvalid,
  input  wire logic                  rready
);
  import acc_pkg::*;

  // ------
  // Declarations
  // ------
  acc_rep_if rep ();

  acc_pstate_t    pst_q;
  logic [2:0]     cnt_q;
  logic           ferr_q;
  logic [7:0]     buf_q [4];
  logic [31:0]    cfg_q;
  logic [LVL_W-1:0] cal_q [4];
  logic [7:0]     cmd_cnt_q;
  logic           rep_start_q;
  acc_kind_t      kind_q;
  logic           cal_do_q;
  logic           cal_gain_q;
  logic           cal_ch_q;
  logic [1:0]     cal_idx;
  logic [LVL_W-1:0] cap_val;
  logic [4:0]     hi;
  logic [4:0]     lo;
  logic           cr_ev;
  logic           addr_hit;
  logic           is_stat;
  logic           chan_ok;
  logic           is_cal;
  logic           take;
  logic           aw_hold_q;
  logic           w_hold_q;
  logic [AW-1:0]  awaddr_q;
  logic [31:0]    wdata_q;
  logic [3:0]     wstrb_q;
  logic           wr_go;
  logic [2:0]     wsel;
  logic [2:0]     rsel;
  logic [31:0]    rd_mux;

  // ------
  // Decoding helpers
  // ------
  function automatic logic [4:0] hex_in(input logic [7:0] c);
    logic [4:0] r;
    r = 5'h00;
    if (c >= 8'h30 && c <= 8'h39) begin
      r = {1'b1, c[3:0]};
    end else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) begin
      r = {1'b1, c[3:0] + 4'h9};
    end
    return r;
  endfunction

  function automatic logic [2:0] reg_sel(input logic [AW-1:0] a);
    logic [2:0]    s;
    logic [AW-1:0] w;
    s = 3'h7;
    w = {a[AW-1:2], 2'b00};
    if (w == AW'(`ACC_OFS_CFG)) begin
      s = 3'h0;
    end
    if (w == AW'(`ACC_OFS_STAT)) begin
      s = 3'h1;
    end
    for (int i = 0; i < 4; i++) begin
      if (w == AW'(`ACC_OFS_CAL + 4 * i)) begin
        s = 3'(2 + i);
      end
    end
    return s;
  endfunction

  // ------
  // Frame collection
  // ------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pst_q  <= ACC_PS_IDLE;
      cnt_q  <= 3'h0;
      ferr_q <= 1'b0;
    end else begin
      if (rx_err) begin
        ferr_q <= 1'b1;
      end
      if (rx_valid) begin
        if (rx_data == `ACC_CH_START) begin // see [RULE1]
          pst_q  <= ACC_PS_BODY;
          cnt_q  <= 3'h0;
          ferr_q <= rx_err;
        end else if (pst_q == ACC_PS_BODY) begin
          if (rx_data == `ACC_CH_CR) begin
            pst_q <= ACC_PS_IDLE;
          end else if (cnt_q != 3'h5) begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 4; i++) begin
        buf_q[i] <= 8'h00;
      end
    end else if (rx_valid && pst_q == ACC_PS_BODY && cnt_q < 3'h4 &&
                 rx_data != `ACC_CH_CR && rx_data != `ACC_CH_START) begin
      buf_q[cnt_q[1:0]] <= rx_data;
    end
  end

  // ------
  // Frame evaluation at carriage return
  // ------
  assign cr_ev    = rx_valid && rx_data == `ACC_CH_CR && pst_q == ACC_PS_BODY;
  assign hi       = hex_in(buf_q[0]);
  assign lo       = hex_in(buf_q[1]);
  assign addr_hit = !ferr_q && !rx_err && cnt_q >= 3'h3 && hi[4] && lo[4] && // see [RULE7]
                    {hi[3:0], lo[3:0]} == cfg_q[`ACC_CFG_ADDR +: 8]; // see [RULE2]
  assign is_stat  = cnt_q == 3'h3 && buf_q[2] == `ACC_CH_STAT; // see [RULE3]
  assign chan_ok  = buf_q[3] == `ACC_CH_GAIN || buf_q[3] == `ACC_CH_OFS;
  assign is_cal   = cnt_q == 3'h4 && chan_ok && // see [RULE10] see [RULE12]
                    (buf_q[2] == `ACC_CH_OFS || buf_q[2] == `ACC_CH_GAIN);
  assign take     = cr_ev && addr_hit && !rep.busy && !rep_start_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rep_start_q <= 1'b0;
      kind_q      <= ACC_ACK;
      cal_do_q    <= 1'b0;
      cal_gain_q  <= 1'b0;
      cal_ch_q    <= 1'b0;
    end else begin
      rep_start_q <= take;
      cal_do_q    <= take && is_cal;
      if (take) begin
        kind_q     <= is_stat ? ACC_STATUS : (is_cal ? ACC_ACK : ACC_NAK); // see [RULE8]
        cal_gain_q <= buf_q[2] == `ACC_CH_GAIN;
        cal_ch_q   <= buf_q[3][0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_cnt_q <= 8'h00;
    end else if (rep_start_q) begin
      cmd_cnt_q <= cmd_cnt_q + 8'h01;
    end
  end

  // ------
  // Reply sender
  // ------
  assign rep.start  = rep_start_q;
  assign rep.kind   = kind_q;
  assign rep.fields = cfg_q; // see [RULE4]

  acc_reply u_reply (
    .clk      (clk),
    .rst_b    (rst_b),
    .rep      (rep.snk),
    .tx_data  (tx_data),
    .tx_valid (tx_valid),
    .tx_ready (tx_ready)
  );

  // ------
  // Calibration capture
  // ------
  assign cal_idx = {cal_ch_q, cal_gain_q};
  assign cap_val = out_level[cal_ch_q];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < 2; c++) begin
        cal_q[2 * c]     <= LVL_W'(`ACC_RST_OFS); // see [RULE15]
        cal_q[2 * c + 1] <= LVL_W'(`ACC_RST_GAIN);
      end
    end else if (cal_do_q) begin
      cal_q[cal_idx] <= cap_val; // see [RULE11] see [RULE13]
    end else if (wr_go && wsel >= 3'h2 && wsel <= 3'h5) begin
      for (int b = 0; b < LVL_W; b++) begin
        if (wstrb_q[b / 8]) begin
          cal_q[wsel[1:0] - 2'h2][b] <= wdata_q[b];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nv_wr_valid <= 1'b0;
      nv_wr_index <= 2'h0;
      nv_wr_data  <= '0;
    end else begin
      nv_wr_valid <= cal_do_q; // see [RULE16]
      if (cal_do_q) begin
        nv_wr_index <= cal_idx;
        nv_wr_data  <= cap_val;
      end
    end
  end

  // ------
  // Register bus write
  // ------
  assign awready = !aw_hold_q && !bvalid;
  assign wready  = !w_hold_q && !bvalid;
  assign wr_go   = aw_hold_q && w_hold_q && !bvalid;
  assign wsel    = reg_sel(awaddr_q);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= `ACC_RESP_OK;
    end else begin
      if (awvalid && awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= (wsel == 3'h7) ? `ACC_RESP_ERR : `ACC_RESP_OK;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= {`ACC_RST_FMT, `ACC_RST_BAUD, `ACC_RST_TYPE, `ACC_RST_ADDR}; // see [RULE5] see [RULE6]
    end else if (wr_go && wsel == 3'h0) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_q[b]) begin
          cfg_q[8 * b +: 8] <= wdata_q[8 * b +: 8];
        end
      end
    end
  end

  // ------
  // Register bus read
  // ------
  assign arready = !rvalid;
  assign rsel    = reg_sel(araddr);

  always_comb begin
    rd_mux = 32'h0;
    unique case (rsel)
      3'h0: rd_mux = cfg_q;
      3'h1: rd_mux = {16'h0, cmd_cnt_q, 4'h0, cal_gain_q, cal_ch_q,
                      pst_q == ACC_PS_BODY, rep.busy};
      3'h2, 3'h3, 3'h4, 3'h5: rd_mux = 32'(cal_q[rsel[1:0] - 2'h2]);
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= `ACC_RESP_OK;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= (rsel == 3'h7) ? `ACC_RESP_ERR : `ACC_RESP_OK;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // ------
  // Checks
  // ------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_take;
    cr_ev && addr_hit && !rep.busy && !rep_start_q;
  endsequence

  sequence s_ack_out;
    cal_do_q && rep_start_q && kind_q == ACC_ACK ##1 rep.busy;
  endsequence

  a_reply_after_cr: assert property (rep_start_q |-> $past(cr_ev)) // see [RULE1]
    else $error("reply without closing carriage return");
  a_addr_match: assert property (rep_start_q |-> // see [RULE2]
    $past({hi[3:0], lo[3:0]} == cfg_q[7:0]))
    else $error("reply to a foreign address");
  a_silent_foreign: assert property (cr_ev && !addr_hit |=> !rep_start_q) // see [RULE7]
    else $error("reply to a bad or foreign frame");
  a_status_kind: assert property (s_take ##0 is_stat |=> // see [RULE3]
    rep_start_q && kind_q == ACC_STATUS ##1 rep.busy)
    else $error("status read not answered");
  a_bad_cmd_nak: assert property (s_take ##0 !is_stat && !is_cal |=> // see [RULE8]
    kind_q == ACC_NAK && !cal_do_q)
    else $error("bad command not refused");
  a_cal_ack: assert property (s_take ##0 is_cal |=> s_ack_out) // see [RULE9]
    else $error("calibration not acknowledged");
  a_chan_range: assert property (cal_do_q |-> $past(chan_ok)) // see [RULE10]
    else $error("calibration on an illegal channel");
  a_gain_opcode: assert property (cal_do_q && cal_gain_q |-> // see [RULE12]
    $past(buf_q[2] == `ACC_CH_GAIN))
    else $error("gain calibration without its opcode");
  a_ofs_capture: assert property (cal_do_q && !cal_gain_q |=> // see [RULE11]
    cal_q[$past(cal_idx)] == $past(cap_val))
    else $error("offset point not captured");
  a_gain_capture: assert property (cal_do_q && cal_gain_q |=> // see [RULE13]
    cal_q[$past(cal_idx)] == $past(cap_val))
    else $error("full scale point not captured");
  a_nv_record: assert property (cal_do_q |=> nv_wr_valid && // see [RULE16]
    nv_wr_data == $past(cap_val) ##1 !nv_wr_valid)
    else $error("calibration not stored");
endmodule
`default_nettype wire

// *** acc_params.svh ***
// Purpose: Constants of the ASCII configuration and calibration command block
// Assumes: Included by bare name after the guard below
// Notes:   Offsets are byte addresses on the register bus
// Summary of operation
// [RULE1] Frames are '$', two address characters, opcode, closed by carriage return
// [RULE2] Address field is two hex characters, 00 to FF
// [RULE3] Matched address with opcode '2' reads the configuration status
// [RULE4] Status reply: '!', address, type, baud, format codes, carriage return
// [RULE5] Baud code 06 reports 9600 baud
// [RULE6] Format code 00 reports engineering units, checksum off
// [RULE7] Syntax error, line error or foreign address gives no reply
// [RULE8] Matched address with bad command replies '?', address, carriage return
// [RULE9] Accepted calibration replies '!', address, carriage return
// [RULE10] Opcode '1' with channel 0 or 1 starts offset calibration
// [RULE11] Offset calibration takes the present channel level as zero point
// [RULE12] Opcode '0' with channel 0 or 1 starts gain calibration
// [RULE13] Gain calibration takes the present channel level as full scale
// [RULE14] Host sets the output level first, offset before gain
// [RULE15] Factory calibration values apply from reset
// [RULE16] Calibration results are handed to non-volatile storage
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// ------
// Characters
// ------
`define ACC_CH_START 8'h24
`define ACC_CH_CR    8'h0d
`define ACC_CH_ACK   8'h21
`define ACC_CH_NAK   8'h3f
`define ACC_CH_GAIN  8'h30
`define ACC_CH_OFS   8'h31
`define ACC_CH_STAT  8'h32

// ------
// Register map and fields
// ------
`define ACC_OFS_CFG   8'h00
`define ACC_OFS_STAT  8'h04
`define ACC_OFS_CAL   8'h08
`define ACC_CFG_ADDR  0
`define ACC_CFG_TYPE  8
`define ACC_CFG_BAUD  16
`define ACC_CFG_FMT   24

// ------
// Reset values
// ------
`define ACC_RST_ADDR  8'h00
`define ACC_RST_TYPE  8'h00
`define ACC_RST_BAUD  8'h06
`define ACC_RST_FMT   8'h00
`define ACC_RST_OFS   16'h0000
`define ACC_RST_GAIN  16'h8000
`define ACC_RESP_OK   2'h0
`define ACC_RESP_ERR  2'h2

`endif

// *** acc_pkg.sv ***
// Purpose: Types of the ASCII configuration and calibration command block
// Assumes: Nothing
// Notes:   Constants live in acc_params.svh
`default_nettype none
package acc_pkg;

  typedef enum logic [1:0] {ACC_ACK, ACC_NAK, ACC_STATUS} acc_kind_t;
  typedef enum logic {ACC_PS_IDLE, ACC_PS_BODY} acc_pstate_t;

endpackage
`default_nettype wire

// *** acc_rep_if.sv ***
// Purpose: Reply request from the interpreter to the reply sender
// Assumes: One clock domain
// Notes:   Fields are {format, baud, type, address}
`timescale 1ns/10ps
`default_nettype none
interface acc_rep_if;
  import acc_pkg::*;
  logic        start;
  acc_kind_t   kind;
  logic [31:0] fields;
  logic        busy;
  modport src (output start, output kind, output fields, input busy);
  modport snk (input start, input kind, input fields, output busy);
endinterface
`default_nettype wire

// *** acc_reply.sv ***
// Purpose: Sends one reply frame as characters
// Assumes: Start arrives only while not busy
// Notes:   Characters leave from flip-flops
`timescale 1ns/10ps
`default_nettype none
`include "acc_params.svh"
module acc_reply (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst_b,
  // Reply request
  acc_rep_if.snk      rep,
  // Characters out
  output var  logic [7:0] tx_data,
  output var  logic       tx_valid,
  input  wire logic       tx_ready
);
  import acc_pkg::*;

  logic [31:0] f_q;
  acc_kind_t   kind_q;
  logic [3:0]  idx_q;
  logic [3:0]  last;
  logic        busy_q;

  function automatic logic [7:0] hex_out(input logic [3:0] n);
    return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  function automatic logic [7:0] char_at(input logic [3:0] i, input acc_kind_t k,
                                         input logic [31:0] f);
    logic [3:0] im1;
    im1 = i - 4'h1;
    if (i == 4'h0) begin
      return (k == ACC_NAK) ? `ACC_CH_NAK : `ACC_CH_ACK; // see [RULE8] see [RULE9]
    end
    if (i > ((k == ACC_STATUS) ? 4'h8 : 4'h2)) begin
      return `ACC_CH_CR;
    end
    return hex_out(f[{im1[2:1], i[0], 2'b00} +: 4]); // see [RULE4]
  endfunction

  assign last     = (kind_q == ACC_STATUS) ? 4'h9 : 4'h3;
  assign rep.busy = busy_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q   <= 1'b0;
      idx_q    <= 4'h0;
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
      f_q      <= 32'h0;
      kind_q   <= ACC_ACK;
    end else if (!busy_q) begin
      if (rep.start) begin
        busy_q   <= 1'b1;
        idx_q    <= 4'h0;
        f_q      <= rep.fields;
        kind_q   <= rep.kind;
        tx_valid <= 1'b1;
        tx_data  <= char_at(4'h0, rep.kind, rep.fields);
      end
    end else if (tx_ready) begin
      if (idx_q == last) begin
        busy_q   <= 1'b0;
        tx_valid <= 1'b0;
      end else begin
        idx_q   <= idx_q + 4'h1;
        tx_data <= char_at(idx_q + 4'h1, kind_q, f_q);
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_lead_char: assert property (rep.start && !busy_q |=> tx_valid && // see [RULE8]
    tx_data == ((kind_q == ACC_NAK) ? `ACC_CH_NAK : `ACC_CH_ACK))
    else $error("reply lead character wrong");
  a_frame_close: assert property (tx_valid && idx_q == last |-> tx_data == `ACC_CH_CR) // see [RULE1]
    else $error("reply not closed by carriage return");
endmodule
`default_nettype wire

// *** acc_host_model.sv ***
// Purpose: Host computer on the serial line of the command block
// Assumes: One clock; characters are handed over as one-cycle pulses
// Notes:   Slow mode raises tx_ready on one cycle in four
`timescale 1ns/10ps
`default_nettype none
module acc_host_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Characters to the block
  output var  logic [7:0] rx_data,
  output var  logic       rx_valid,
  output var  logic       rx_err,
  // Reply characters from the block
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output var  logic       tx_ready
);
  logic [7:0] got_q[$];
  logic       slow;
  logic [1:0] stall_q;

  initial begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    rx_err   = 1'b0;
    tx_ready = 1'b1;
    slow     = 1'b0;
    stall_q  = 2'h0;
  end

  // ------
  // Reply side
  // ------
  always @(posedge clk) begin
    stall_q  <= stall_q + 2'h1;
    tx_ready <= !slow || (stall_q == 2'h3);
    if (rst_b && tx_valid && tx_ready) begin
      got_q.push_back(tx_data);
    end
  end

  // ------
  // Frame side
  // ------
  // Caller builds '$', hex address, opcode, CR; err_at poisons that character
  task automatic send_frame(input string s, input int err_at);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk);
      rx_data  <= s[i];
      rx_valid <= 1'b1;
      rx_err   <= (i == err_at);
      @(posedge clk);
      rx_data  <= ~s[i];
      rx_valid <= 1'b0;
      rx_err   <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Purpose: Self-checking bench of the command block
// Assumes: Host model drives the serial side, bench drives AXI4-Lite
// Notes:   Expected replies are spelled out per scenario
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic                  clk;
  logic                  rst_b;
  logic [7:0]            rx_data, tx_data, awaddr, araddr;
  logic                  rx_valid, rx_err, tx_valid, tx_ready;
  logic [1:0][15:0]      out_level;
  logic                  nv_wr_valid;
  logic [1:0]            nv_wr_index, bresp, rresp;
  logic [15:0]           nv_wr_data;
  logic [31:0]           wdata, rdata;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready;
  int                    n_errors = 0;
  int                    checks = 0;
  int                    nv_n = 0;
  logic [1:0]            nv_idx;
  logic [15:0]           nv_dat;

  acc_top acc_top_i (.clk(clk), .rst_b(rst_b), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_err(rx_err), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .out_level(out_level), .nv_wr_valid(nv_wr_valid), .nv_wr_index(nv_wr_index),
    .nv_wr_data(nv_wr_data), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  acc_host_model host_i (.clk(clk), .rst_b(rst_b), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_err(rx_err), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

  // Records each calibration store pulse
  always @(posedge clk) begin
    if (nv_wr_valid === 1'b1) begin
      nv_n   <= nv_n + 1;
      nv_idx <= nv_wr_index;
      nv_dat <= nv_wr_data;
    end
  end

  // ------
  // Common tasks
  // ------
  task automatic end_of_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic hang(input int n);
    if (n >= 100) begin
      n_errors++;
      $display("CHECK FAILED handshake expected done seen timeout");
      end_of_test();
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw;
    int   n;
    n = 0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
    end while ((awvalid && !ta || wvalid && !tw) && n < 100);
    hang(n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!bvalid && n < 100);
    hang(n);
    r = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (!arready && n < 100);
    hang(n);
    @(posedge clk);
    arvalid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!rvalid && n < 100);
    hang(n);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask

  // Empty string means the block must stay silent
  task automatic expect_reply(input string s);
    int n;
    n = 0;
    while (host_i.got_q.size() < s.len() && n < 400) begin
      @(negedge clk);
      n++;
    end
    repeat (30) @(negedge clk);
    `CHK("reply length", s.len(), host_i.got_q.size())
    for (int i = 0; i < s.len() && i < host_i.got_q.size(); i++) begin
      `CHK("reply char", s[i], host_i.got_q[i])
    end
    host_i.got_q.delete();
  endtask

  // ------
  // Scenarios
  // ------
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(8'h00, d, r);
    `CHK("cfg reset", 32'h00060000, d)
    axi_rd(8'h08, d, r);
    `CHK("ch0 offset reset", 16'h0000, d[15:0])
    axi_rd(8'h14, d, r);
    `CHK("ch1 gain reset", 16'h8000, d[15:0])
    axi_rd(8'h40, d, r);
    `CHK("unmapped read", 2'h2, r)
    axi_wr(8'h44, 32'h0, r);
    `CHK("unmapped write", 2'h2, r)
  endtask

  task automatic t_status();
    logic [1:0] r;
    host_i.send_frame("$002\015", -1);
    expect_reply("!00000600\015");
    axi_wr(8'h00, 32'h00060fab, r);
    host_i.send_frame("$aB2\015", -1);
    expect_reply("!AB0F0600\015");
    axi_wr(8'h00, 32'h00060f30, r);
    host_i.slow = 1'b1;
    host_i.send_frame("$302\015", -1);
    expect_reply("!300F0600\015");
    host_i.slow = 1'b0;
  endtask

  task automatic t_refuse();
    int n0;
    n0 = nv_n;
    host_i.send_frame("$312\015", -1);
    expect_reply("");
    host_i.send_frame("$3010\015", 2);
    expect_reply("");
    host_i.send_frame("$3\015", -1);
    expect_reply("");
    host_i.send_frame("$309\015", -1);
    expect_reply("?30\015");
    host_i.send_frame("$3012\015", -1);
    expect_reply("?30\015");
    host_i.send_frame("$30M\015", -1);
    expect_reply("?30\015");
    `CHK("no store", n0, nv_n)
  endtask

  // Offset then gain per channel, as the host must order them
  task automatic t_cal();
    logic [15:0] lvl;
    logic [31:0] d;
    logic [1:0]  r;
    int          n0;
    for (int k = 0; k < 4; k++) begin
      lvl = 16'h1234 + 16'(k) * 16'h1111;
      @(posedge clk);
      out_level[k/2]     <= lvl;
      out_level[1 - k/2] <= ~lvl;
      n0 = nv_n;
      host_i.send_frame($sformatf("$30%0d%0d\015", 1 - k % 2, k / 2), -1);
      expect_reply("!30\015");
      `CHK("store count", n0 + 1, nv_n)
      `CHK("store index", 2'(k), nv_idx)
      `CHK("store value", lvl, nv_dat)
      axi_rd(8'h08 + 8'(4 * k), d, r);
      `CHK("cal register", lvl, d[15:0])
    end
    // Ten replies so far, last capture was channel 1 gain, line idle
    axi_rd(8'h04, d, r);
    `CHK("status word", 32'h00000a0c, d)
  endtask

  // ------
  // Clock, reset and sequence
  // ------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    rst_b     = 1'b0;
    out_level = '0;
    awaddr    = 8'h00;
    araddr    = 8'h00;
    wdata     = 32'h0;
    awvalid   = 1'b0;
    wvalid    = 1'b0;
    bready    = 1'b0;
    arvalid   = 1'b0;
    rready    = 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_status();
    t_refuse();
    t_cal();
    end_of_test();
  end
endmodule
`default_nettype wire
